//--- hw/ufc_pkg.sv
// Package for the UART flow control and multidrop addressing block
package ufc_pkg;
   // ---------------------------------------------------------------
   // Register map (APB byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] ADDR_ADDR   = 8'h04;
   localparam logic [7:0] STAT_ADDR   = 8'h08;
   // ---------------------------------------------------------------
   // Control, address and status field positions
   // ---------------------------------------------------------------
   localparam int CTL_CTS_EN   = 0;
   localparam int CTL_RTS_EN   = 1;
   localparam int CTL_RTS_LVL  = 2;
   localparam int CTL_GAP_MODE = 3;
   localparam int CTL_NINE     = 4;
   localparam int CTL_NINE_VAL = 5;
   localparam int CTL_GAP_REQ  = 6;
   localparam int CTL_LVL_LSB  = 8;
   localparam int CTL_UART_EN  = 12;
   localparam int ADR_NODE_LSB = 0;
   localparam int ADR_MASK_LSB = 8;
   localparam int ST_TAG       = 0;
   localparam int ST_BUSY      = 1;
   localparam int ST_HIT       = 2;
   localparam int ST_CTS       = 3;
   localparam int ST_RTS       = 4;
   localparam int ST_PASS      = 5;
   // ---------------------------------------------------------------
   // Reset values and timing in bit times
   // ---------------------------------------------------------------
   localparam logic [7:0] MASK_RST  = 8'hFF;
   localparam logic [7:0] NODE_RST  = 8'h00;
   localparam logic [3:0] LVL_RST   = 4'h4;
   localparam logic [3:0] IDLE_BITS = 4'hA;
   localparam logic [3:0] GAP_BITS  = 4'hB;
endpackage : ufc_pkg

//--- hw/ufc_top.sv
// Flow control, idle-line and 9-bit address logic of a UART
//
// Summary of operation
// - RTS and CTS both active low
// - Two enables select RTS and CTS control
// - Auto RTS ignores manual level bit
// - RTS high at watermark, low below
// - No RTS control: receive until FIFO full
// - CTS low and data needed to start
// - CTS high finishes current character first
// - CTS disabled: send until FIFO empty
// - Ten idle bits detect gap, stop baud
// - Gap mode uses no parity, 8 bits
// - Address after gap gates following characters
// - Tag set on gap, cleared on match
// - Gap request sends eleven idle bits
// - Gap request clears after address sent
// - Busy spans gap, sends, receive idle
// - Ninth-bit mode ignores parity, 8 bits
// - Tagged byte compared; mismatch drops data
// - Mask selects compared bits, resets 0xFF
// - Transmit sends ninth bit value
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ufc_top #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        srst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Link pins
   input  wire logic        cts_n_in,
   output logic             rts_n_out,
   // UART core: receive side
   input  wire logic [4:0]  rx_fill_in,
   input  wire logic        rx_char_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_ninth_in,
   input  wire logic        rx_start_in,
   input  wire logic        rx_bit_tick_in,
   input  wire logic        rx_line_in,
   output logic             rx_store_out,
   output logic             baud_halt_out,
   // UART core: transmit side
   input  wire logic        tx_fifo_empty_in,
   input  wire logic        tx_shift_ready_in,
   input  wire logic        tx_bit_tick_in,
   input  wire logic        tx_done_in,
   output logic             tx_start_out,
   output logic             tx_ninth_out,
   output logic             tx_gap_out,
   output logic             busy_out,
   output logic             node_hit_out
);
   initial begin
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16) begin
         $error("ufc_top: FIFO_DEPTH must be 2..16");
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {UFC_TX_IDLE, UFC_TX_GAP, UFC_TX_SEND} ufc_tx_t;

   // Control fields
   logic        cts_en_r;
   logic        rts_en_r;
   logic        rts_lvl_r;
   logic        gap_mode_r;
   logic        nine_r;
   logic        nine_val_r;
   logic        gap_req_r;
   logic        uart_en_r;
   logic [3:0]  lvl_r;
   logic [7:0]  node_r;
   logic [7:0]  mask_r;
   // Clear-to-send synchroniser
   logic        cts_s1_r;
   logic        cts_s2_r;
   // Receive addressing state
   logic        tag_r;
   logic        pass_r;
   logic        hit_r;
   logic        rx_busy_r;
   logic        halt_r;
   logic [3:0]  rx_idle_cnt_r;
   // Transmit gap state
   logic [3:0]  gap_cnt_r;
   logic        gap_addr_r;
   ufc_tx_t     tx_st_r;
   // Output flops
   logic        rts_n_r;
   logic        store_r;
   logic        start_r;
   logic        hit_pulse_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire bus_setup = psel_in && !penable_in;
   wire wr_ctrl   = bus_setup && pwrite_in && (paddr_in == ufc_pkg::CTRL_ADDR);
   wire wr_addr   = bus_setup && pwrite_in && (paddr_in == ufc_pkg::ADDR_ADDR);
   wire hit_ctrl  = (paddr_in == ufc_pkg::CTRL_ADDR);
   wire hit_adr   = (paddr_in == ufc_pkg::ADDR_ADDR);
   wire hit_stat  = (paddr_in == ufc_pkg::STAT_ADDR);
   wire bad_addr  = !(hit_ctrl || hit_adr || hit_stat);

   // Address compare under the node mask
   function automatic logic node_match(input logic [7:0] b, input logic [7:0] n,
                                       input logic [7:0] m);
      node_match = ((b ^ n) & m) == 8'h00;
   endfunction : node_match

   // ---------------------------------------------------------------
   // Flow control
   // ---------------------------------------------------------------
   wire        cts_ok    = !cts_s2_r;
   wire [4:0]  lvl_ext   = {1'b0, lvl_r};
   wire        at_mark   = rx_fill_in >= lvl_ext;
   wire        rts_n_nxt = rts_en_r ? at_mark : rts_lvl_r;
   wire        cts_gate  = cts_en_r ? cts_ok : 1'b1;
   wire        can_send  = uart_en_r && !tx_fifo_empty_in && tx_shift_ready_in
                           && cts_gate;

   // ---------------------------------------------------------------
   // Receive addressing
   // ---------------------------------------------------------------
   wire rx_match  = node_match(rx_byte_in, node_r, mask_r);
   wire addr_nine = nine_r && rx_ninth_in;
   wire addr_gap  = gap_mode_r && tag_r && !pass_r;
   wire is_addr   = rx_char_in && (addr_nine || addr_gap);
   wire multi     = nine_r || gap_mode_r;
   wire pass_nxt  = is_addr ? rx_match : pass_r;
   wire store_nxt = rx_char_in && uart_en_r && (!multi || pass_nxt)
                    && (rx_fill_in < 5'(FIFO_DEPTH));
   wire idle_seen = gap_mode_r && rx_bit_tick_in && rx_line_in
                    && (rx_idle_cnt_r == ufc_pkg::IDLE_BITS - 4'h1);

   // ---------------------------------------------------------------
   // Transmit gap sequencer
   // ---------------------------------------------------------------
   wire gap_last = tx_bit_tick_in && (gap_cnt_r == ufc_pkg::GAP_BITS - 4'h1);

   // ---------------------------------------------------------------
   // Clear-to-send synchroniser
   // ---------------------------------------------------------------
   // The pin comes from the peer's clock domain; only the second flop is read
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cts_s1_r <= 1'b1;
         cts_s2_r <= 1'b1;
      end else begin
         cts_s1_r <= cts_n_in;
         cts_s2_r <= cts_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cts_en_r   <= 1'b0;
         rts_en_r   <= 1'b0;
         rts_lvl_r  <= 1'b1;
         gap_mode_r <= 1'b0;
         nine_r     <= 1'b0;
         nine_val_r <= 1'b0;
         uart_en_r  <= 1'b0;
         lvl_r      <= ufc_pkg::LVL_RST;
         node_r     <= ufc_pkg::NODE_RST;
         mask_r     <= ufc_pkg::MASK_RST;
      end else begin
         if (wr_ctrl) begin
            cts_en_r   <= pwdata_in[ufc_pkg::CTL_CTS_EN];
            rts_en_r   <= pwdata_in[ufc_pkg::CTL_RTS_EN];
            rts_lvl_r  <= pwdata_in[ufc_pkg::CTL_RTS_LVL];
            gap_mode_r <= pwdata_in[ufc_pkg::CTL_GAP_MODE];
            nine_r     <= pwdata_in[ufc_pkg::CTL_NINE];
            nine_val_r <= pwdata_in[ufc_pkg::CTL_NINE_VAL];
            uart_en_r  <= pwdata_in[ufc_pkg::CTL_UART_EN];
            lvl_r      <= pwdata_in[ufc_pkg::CTL_LVL_LSB +: 4];
         end
         if (wr_addr) begin
            node_r <= pwdata_in[ufc_pkg::ADR_NODE_LSB +: 8];
            mask_r <= pwdata_in[ufc_pkg::ADR_MASK_LSB +: 8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Receive side: gap detection, tag, pass gate
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tag_r         <= 1'b0;
         pass_r        <= 1'b0;
         hit_r         <= 1'b0;
         rx_busy_r     <= 1'b0;
         halt_r        <= 1'b0;
         rx_idle_cnt_r <= 4'h0;
         rts_n_r       <= 1'b1;
         store_r       <= 1'b0;
         hit_pulse_r   <= 1'b0;
      end else begin
         rts_n_r     <= rts_n_nxt;
         store_r     <= store_nxt;
         hit_pulse_r <= is_addr && rx_match && nine_r;
         // A gap closes the block, so the next character is an address again
         if (is_addr) begin
            pass_r <= rx_match;
         end else if (idle_seen) begin
            pass_r <= 1'b0;
         end
         // Set wins over the software clear of the hit flag
         if (is_addr && rx_match) begin
            hit_r <= 1'b1;
         end else if (wr_ctrl) begin
            hit_r <= 1'b0;
         end
         if (idle_seen || (is_addr && !rx_match)) begin
            tag_r <= 1'b1;
         end else if (is_addr && rx_match) begin
            tag_r <= 1'b0;
         end
         if (rx_start_in) begin
            halt_r        <= 1'b0;
            rx_busy_r     <= 1'b1;
            rx_idle_cnt_r <= 4'h0;
         end else if (idle_seen) begin
            halt_r        <= 1'b1;
            rx_busy_r     <= 1'b0;
            rx_idle_cnt_r <= 4'h0;
         end else if (gap_mode_r && rx_bit_tick_in && !halt_r) begin
            rx_idle_cnt_r <= rx_line_in ? rx_idle_cnt_r + 4'h1 : 4'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit side: gap insertion and start gating
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         gap_req_r  <= 1'b0;
         gap_cnt_r  <= 4'h0;
         gap_addr_r <= 1'b0;
         tx_st_r    <= UFC_TX_IDLE;
         start_r    <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (wr_ctrl && pwdata_in[ufc_pkg::CTL_GAP_REQ]) begin
            gap_req_r <= 1'b1;
         end else if (gap_addr_r && tx_done_in) begin
            gap_req_r <= 1'b0;
         end
         if (gap_addr_r && tx_done_in) begin
            gap_addr_r <= 1'b0;
         end
         case (tx_st_r)
            UFC_TX_IDLE: begin
               // Wait for the shifter, so an ongoing character finishes first
               if (gap_mode_r && gap_req_r && !gap_addr_r && tx_shift_ready_in) begin
                  tx_st_r   <= UFC_TX_GAP;
                  gap_cnt_r <= 4'h0;
               end else if (can_send) begin
                  start_r <= 1'b1;
                  tx_st_r <= UFC_TX_SEND;
               end
            end
            UFC_TX_GAP: begin
               if (gap_last) begin
                  tx_st_r    <= UFC_TX_IDLE;
                  gap_addr_r <= 1'b1;
               end else if (tx_bit_tick_in) begin
                  gap_cnt_r <= gap_cnt_r + 4'h1;
               end
            end
            UFC_TX_SEND: begin
               // CTS is looked at again only once this character is done
               if (tx_done_in) begin
                  tx_st_r <= UFC_TX_IDLE;
               end
            end
            default: tx_st_r <= UFC_TX_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic tx_ninth_r;
   logic tx_gap_r;
   logic busy_r;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tx_ninth_r <= 1'b0;
         tx_gap_r   <= 1'b0;
         busy_r     <= 1'b0;
      end else begin
         tx_ninth_r <= nine_r && nine_val_r;
         tx_gap_r   <= (tx_st_r == UFC_TX_GAP);
         busy_r     <= (tx_st_r != UFC_TX_IDLE) || gap_addr_r
                       || (gap_mode_r && rx_busy_r);
      end
   end

   // ---------------------------------------------------------------
   // APB read path: answered in the access cycle, no wait states
   // ---------------------------------------------------------------
   wire [31:0] ctrl_rd = {19'h0, uart_en_r, lvl_r, 1'b0, gap_req_r, nine_val_r,
                          nine_r, gap_mode_r, rts_lvl_r, rts_en_r, cts_en_r};
   wire [31:0] adr_rd  = {16'h0, mask_r, node_r};
   wire [31:0] stat_rd = {26'h0, pass_r, rts_n_r, cts_ok, hit_r, busy_r, tag_r};
   wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd : hit_adr ? adr_rd :
                         hit_stat ? stat_rd : 32'h0000_0000;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= bus_setup;
         pslverr_r <= bus_setup && bad_addr;
         prdata_r  <= (bus_setup && !pwrite_in) ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata_out    = prdata_r;
   assign pready_out    = pready_r;
   assign pslverr_out   = pslverr_r;
   assign rts_n_out     = rts_n_r;
   assign rx_store_out  = store_r;
   assign baud_halt_out = halt_r;
   assign tx_start_out  = start_r;
   assign tx_ninth_out  = tx_ninth_r;
   assign tx_gap_out    = tx_gap_r;
   assign busy_out      = busy_r;
   assign node_hit_out  = hit_pulse_r;
endmodule : ufc_top

//--- test/ufc_top_props.sv
// Port-level checks for the flow control and addressing block
`timescale 1ns/1ps
module ufc_top_props (
   input wire logic        ref_clk_in,
   input wire logic        srst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        cts_n_in,
   input wire logic        rts_n_out,
   input wire logic [4:0]  rx_fill_in,
   input wire logic        rx_char_in,
   input wire logic        rx_store_out,
   input wire logic        tx_fifo_empty_in,
   input wire logic        tx_start_out,
   input wire logic        tx_gap_out,
   input wire logic        node_hit_out
);
   // ---------------------------------------------------------------
   // Shadow of the control word, taken at the same setup edge
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   wire         wr_ctrl = psel_in && !penable_in && pwrite_in && paddr_in == ufc_pkg::CTRL_ADDR;
   wire         bad_adr = paddr_in > ufc_pkg::STAT_ADDR || paddr_in[1:0] != 2'b00;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) ctrl_r <= {20'h0_0000, ufc_pkg::LVL_RST, 8'h04};
      else if (wr_ctrl) ctrl_r <= pwdata_in;
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_cts_held;
      (ctrl_r[ufc_pkg::CTL_CTS_EN] && cts_n_in) [*4];
   endsequence
   a_ready_next: assert property (s_setup |=> pready_out) else $error("no pready after setup");
   a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready too long");
   a_slverr_map: assert property (s_setup ##0 bad_adr |=> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
   a_rst_rts: assert property (!srst_in && $past(srst_in) |-> rts_n_out)
      else $error("rts not high after reset");
   a_rts_auto: assert property (!$past(srst_in) && $past(ctrl_r[ufc_pkg::CTL_RTS_EN])
      |-> rts_n_out == ($past(rx_fill_in) >= {1'b0, $past(ctrl_r[11:8])}))
      else $error("rts does not follow watermark");
   a_rts_manual: assert property (!$past(srst_in) && !$past(ctrl_r[ufc_pkg::CTL_RTS_EN])
      |-> rts_n_out == $past(ctrl_r[ufc_pkg::CTL_RTS_LVL])) else $error("rts not manual");
   a_cts_blocks: assert property (s_cts_held |-> !tx_start_out)
      else $error("start while cts high");
   a_start_data: assert property (tx_start_out |-> $past(!tx_fifo_empty_in))
      else $error("start with empty fifo");
   a_store_cause: assert property (rx_store_out |-> $past(rx_char_in))
      else $error("store without char");
   a_gap_quiet: assert property (tx_gap_out |-> !tx_start_out)
      else $error("start during gap");
   a_hit_pulse: assert property (node_hit_out |=> !node_hit_out)
      else $error("hit longer than a cycle");
endmodule : ufc_top_props

bind ufc_top ufc_top_props u_props (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .cts_n_in(cts_n_in), .rts_n_out(rts_n_out),
   .rx_fill_in(rx_fill_in), .rx_char_in(rx_char_in), .rx_store_out(rx_store_out),
   .tx_fifo_empty_in(tx_fifo_empty_in), .tx_start_out(tx_start_out),
   .tx_gap_out(tx_gap_out), .node_hit_out(node_hit_out));

//--- test/ufc_peer.sv
// Far-side UART model: its request line feeds our clear-to-send
`timescale 1ns/1ps
module ufc_peer (
   // Clock
   input  wire logic ref_clk_in,
   // Peer state and link pins
   input  wire logic full_in,
   input  wire logic rts_n_in,
   output logic      cts_n_out,
   output logic      may_send_out
);
   // Bench raises full_in one level early so a character in flight still fits
   always_ff @(posedge ref_clk_in) cts_n_out <= full_in;
   assign may_send_out = !rts_n_in;
endmodule : ufc_peer

//--- test/test_ufc_top.sv
// Self-checking bench for the flow control and addressing block
`timescale 1ns/1ps
module test_ufc_top;
   localparam logic [31:0] EN = 32'h0000_0001 << ufc_pkg::CTL_UART_EN;
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, full = 1;
   logic        rx_char = 0, rx_ninth = 0, rx_start = 0, rx_tick = 0, rx_line = 1;
   logic        tx_empty = 1, tx_ready = 1, tx_tick = 0, tx_done = 0, tx_tick_d = 0;
   logic [7:0]  paddr = 8'h00, rx_byte = 8'h00, r;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [4:0]  rx_fill = 5'h00;
   logic [4:0]  fl [4] = '{5'h04, 5'h05, 5'h09, 5'h04};
   logic        pready, pslverr, cts_n, rts_n, halt, tx_start, tx_gap, hit, may_send;
   logic [31:0] exp_q[$], msk_q[$];
   logic        err_q[$];
   int          n_fail = 0, comparisons = 0, cyc = 0, starts, hits, gap_ticks, seed;
   ufc_top dut (.ref_clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .cts_n_in(cts_n), .rts_n_out(rts_n),
      .rx_fill_in(rx_fill), .rx_char_in(rx_char), .rx_byte_in(rx_byte),
      .rx_ninth_in(rx_ninth), .rx_start_in(rx_start), .rx_bit_tick_in(rx_tick),
      .rx_line_in(rx_line), .rx_store_out(), .baud_halt_out(halt),
      .tx_fifo_empty_in(tx_empty), .tx_shift_ready_in(tx_ready), .tx_bit_tick_in(tx_tick),
      .tx_done_in(tx_done), .tx_start_out(tx_start), .tx_ninth_out(), .tx_gap_out(tx_gap),
      .busy_out(), .node_hit_out(hit));
   ufc_peer peer (.ref_clk_in(clk), .full_in(full), .rts_n_in(rts_n), .cts_n_out(cts_n),
      .may_send_out(may_send));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
            input logic e);
      if (!w) begin
         exp_q.push_back(d); msk_q.push_back(m); err_q.push_back(e);
      end
      @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0000_0000;
      @(posedge clk); penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 0; penable <= 0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0000_0000, 1'b0);
      repeat (2) @(posedge clk);
   endtask : wr
   task send(input logic [7:0] b, input logic n);
      @(posedge clk); rx_char <= 1; rx_byte <= b; rx_ninth <= n;
      @(posedge clk); rx_char <= 0;
      repeat (4) @(posedge clk);
   endtask : send
   task close_out;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   // Read answers are matched against the oldest note
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
         chk(prdata & msk_q[0], exp_q[0] & msk_q[0]);
         chk({31'h0, pslverr}, {31'h0, err_q[0]});
         void'(exp_q.pop_front()); void'(msk_q.pop_front()); void'(err_q.pop_front());
      end
   end
   // Core stand-in: bit ticks, done after each start, event counters, timeout
   always @(posedge clk) begin
      cyc++;
      tx_tick <= (cyc % 4 == 0);
      rx_tick <= (cyc % 4 == 2);
      tx_done <= (tx_start === 1'b1);
      if (tx_start === 1'b1) starts++;
      if (hit === 1'b1) hits++;
      // The gap flag lags the sequencer by one cycle, so pair it with a lagged tick
      tx_tick_d <= tx_tick;
      if (tx_gap === 1'b1 && tx_tick_d === 1'b1) gap_ticks++;
      if (cyc >= 20000) begin
         n_fail++;
         close_out;
      end
   end
   initial begin
      seed = $urandom(32'hfa090768);
      repeat (16) @(posedge clk);
      srst <= 0;
      chk(rts_n, 1);
      apb(0, ufc_pkg::ADDR_ADDR, 32'h0000_FF00, 32'h0000_FFFF, 0);
      apb(0, ufc_pkg::STAT_ADDR, 0, ONE << ufc_pkg::ST_TAG, 0);
      apb(0, 8'h0C, 0, 32'hFFFF_FFFF, 1);
      $display("reset test done");
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_RTS_EN | 32'h0000_0500);
      foreach (fl[i]) begin
         rx_fill <= fl[i];
         repeat (3) @(posedge clk);
         chk(rts_n, fl[i] >= 5'h05);
         chk(may_send, fl[i] < 5'h05);
      end
      rx_fill <= 5'h09;
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_RTS_LVL);
      chk(rts_n, 1);
      wr(ufc_pkg::CTRL_ADDR, EN);
      chk(rts_n, 0);
      $display("rts test done");
      tx_empty <= 0;
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_CTS_EN);
      starts = 0;
      repeat (20) @(posedge clk);
      chk(starts, 0);
      full <= 0;
      repeat (20) @(posedge clk);
      chk(starts > 0, 1);
      full <= 1;
      wr(ufc_pkg::CTRL_ADDR, EN);
      starts = 0;
      repeat (20) @(posedge clk);
      chk(starts > 0, 1);
      tx_empty <= 1;
      repeat (3) @(posedge clk);
      starts = 0;
      repeat (20) @(posedge clk);
      chk(starts, 0);
      $display("cts test done");
      r = 8'($urandom);
      wr(ufc_pkg::ADDR_ADDR, {16'h0000, 8'hFF, r});
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_NINE);
      hits = 0;
      send(r, 1);
      chk(hits, 1);
      send(r ^ 8'h01, 1);
      chk(hits, 1);
      wr(ufc_pkg::ADDR_ADDR, {16'h0000, 8'hFE, r});
      send(r ^ 8'h01, 1);
      chk(hits, 2);
      $display("ninth bit test done");
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_GAP_MODE);
      repeat (80) @(posedge clk);
      chk(halt, 1);
      apb(0, ufc_pkg::STAT_ADDR, ONE, ONE << ufc_pkg::ST_TAG, 0);
      @(posedge clk); rx_start <= 1;
      @(posedge clk); rx_start <= 0;
      send(r, 0);
      apb(0, ufc_pkg::STAT_ADDR, 0, ONE << ufc_pkg::ST_TAG, 0);
      $display("idle detect test done");
      tx_empty <= 0;
      gap_ticks = 0;
      wr(ufc_pkg::CTRL_ADDR, EN | ONE << ufc_pkg::CTL_GAP_MODE | ONE << ufc_pkg::CTL_GAP_REQ);
      repeat (80) @(posedge clk);
      chk(gap_ticks, 11);
      tx_empty <= 1;
      apb(0, ufc_pkg::CTRL_ADDR, 0, ONE << ufc_pkg::CTL_GAP_REQ, 0);
      repeat (4) @(posedge clk);
      $display("gap send test done");
      close_out;
   end
endmodule : test_ufc_top
